/* qrs_consts.svh */
// Holds the clock rate, times, counter limits and comparator indices of the quasi-resonant switch timing block as macros.
// Assumes it is included by bare name wherever a count, index or reset value is needed.
`ifndef QRS_CONSTS_SVH
`define QRS_CONSTS_SVH

// ************************************************************
// Clock rate and time-to-cycle conversion
// ************************************************************
`define QRS_CLK_MHZ            64'd250
// A least time rounds up, a longest time rounds down, neither below one cycle.
`define QRS_CYC_CEIL(ns)       (((64'(ns) * `QRS_CLK_MHZ + 64'd999) / 64'd1000) > 64'd0 ? \
                                ((64'(ns) * `QRS_CLK_MHZ + 64'd999) / 64'd1000) : 64'd1)
`define QRS_CYC_FLOOR(ns)      (((64'(ns) * `QRS_CLK_MHZ) / 64'd1000) > 64'd0 ? \
                                ((64'(ns) * `QRS_CLK_MHZ) / 64'd1000) : 64'd1)

// ************************************************************
// Times in nanoseconds
// ************************************************************
`define QRS_LEADING_BLANK_NS   220
`define QRS_SW_BLANK_NS        190
`define QRS_SUPP_LONG_NS       2500
`define QRS_SUPP_SHORT_NS      1000
`define QRS_OVP_BLANK_NS       1000
`define QRS_MAX_OFF_NS         50000
`define QRS_MAX_ON_NS          30000
`define QRS_BURST_BLANK_NS     20000000
`define QRS_SKIP_PERIOD_NS     48000000

// ************************************************************
// Counter limits and reset values
// ************************************************************
`define QRS_VALLEY_MIN         3'h0
`define QRS_VALLEY_MAX         3'h7
`define QRS_SKIP_MIN           3'h1
`define QRS_SKIP_MAX           3'h7
`define QRS_SKIP_RESET         3'h1
`define QRS_CUR_LIMIT_BASE     8'hFF

// ************************************************************
// Comparator input indices
// ************************************************************
`define QRS_NCMP               10
`define QRS_CMP_VALLEY         0
`define QRS_CMP_OVP            1
`define QRS_CMP_SUPP_SEL       2
`define QRS_CMP_PWM            3
`define QRS_CMP_OCL            4
`define QRS_CMP_SW             5
`define QRS_CMP_FB_ZL          6
`define QRS_CMP_FB_ZH          7
`define QRS_CMP_FB_R1          8
`define QRS_CMP_FB_EB          9

`endif

/* qrs_pkg.sv */
// Holds the types shared by the quasi-resonant switch timing block.
// Assumes compilation before any module that imports it.
package qrs_pkg;

  // ************************************************************
  // Switching state, one-hot
  // ************************************************************
  typedef enum logic [3:0] {
    QRS_ST_ON    = 4'h1,
    QRS_ST_SUPP  = 4'h2,
    QRS_ST_WAIT  = 4'h4,
    QRS_ST_LATCH = 4'h8
  } qrs_state_e;

  // Three-bit valley and skip counts.
  typedef logic [2:0] qrs_cnt3_t;

endpackage

/* qrs_cmp_filter.sv */
// Holds the comparator synchroniser with an optional persistence filter.
// Assumes the raw comparator level is asynchronous to sys_clk_i.
`timescale 1ns/1ps
`include "qrs_consts.svh"

module qrs_cmp_filter #(
  parameter int unsigned BLANK_CYC = 0,
  parameter int unsigned CW        = 32
) (
  // Clock and reset.
  input  wire logic sys_clk_i,
  input  wire logic srst_i,
  // Comparator in, qualifier in.
  input  wire logic raw_i,
  input  wire logic en_i,
  // Synchronised level and filtered hit.
  output logic      level_o,
  output logic      hit_o
);

  // ************************************************************
  // Two-flop synchroniser and persistence counter
  // ************************************************************
  logic          meta_q;
  logic          sync_q;
  logic [CW-1:0] run_q;
  logic [CW-1:0] run_d;

  // The run length restarts whenever the qualified level drops, so spikes of up to BLANK_CYC cycles never hit.
  always_comb begin
    run_d = run_q;
    if (!(en_i && sync_q)) begin
      run_d = '0;
    end else if (run_q < CW'(BLANK_CYC)) begin
      run_d = run_q + 1'b1;
    end
  end

  // Only sync_q reads the first flop.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      run_q  <= '0;
    end else begin
      meta_q <= raw_i;
      sync_q <= meta_q;
      run_q  <= run_d;
    end
  end

  // With a zero blank the hit follows the qualified level at once.
  assign level_o = sync_q;
  assign hit_o   = en_i && sync_q && (run_q >= CW'(BLANK_CYC));

endmodule

/* qrs_switch_timing.sv */
// Holds the switching decision logic of a quasi-resonant flyback controller.
// Assumes comparator decisions arrive as levels from the analogue front end and the
// gate request drives an external gate gate_drive_output.
//
// Overview of operation
// [R1] Valley counter saturates between 0 and 7 and never wraps.
// [R2] While off, each falling crossing of the valley threshold adds one valley.
// [R3] Valley counter clears whenever the gate drive rises.
// [R4] Overvoltage seen during off-time latches off after a fixed blanking interval.
// [R5] Suppression uses the long time below its threshold, the short time above.
// [R6] Gate stays low for the whole ringing-suppression interval after turn-off.
// [R7] After suppression, turn on once valley count reaches the skip count.
// [R8] After the maximum off-time, turn on regardless of counters or sense input.
// [R9] Turn off when scaled current sense exceeds the feedback level.
// [R10] PWM and overcurrent comparators are ignored for the leading blank time after turn-on.
// [R11] Force gate low once high longer than the maximum on-time.
// [R12] Overcurrent after leading blank turns the gate off at once.
// [R13] Shorted-winding comparator is spike filtered; persistent hits latch off.
// [R14] Current limit is lowered by an offset from the foldback current excess.
// [R15] Burst flag sets when low feedback and skip count 7 persist long enough.
// [R16] Skip counter updates each 48ms period: up, hold, down or force to 1.
// [R17] Comparators are synchronised and every time is a parameterised cycle count.
`timescale 1ns/1ps
`include "qrs_consts.svh"

module qrs_switch_timing #(
  parameter int unsigned LIM_W          = 8,
  parameter int unsigned MAX_OFF_CYC    = 32'(`QRS_CYC_FLOOR(`QRS_MAX_OFF_NS)),
  parameter int unsigned MAX_ON_CYC     = 32'(`QRS_CYC_FLOOR(`QRS_MAX_ON_NS)),
  parameter int unsigned BURST_BLANK_CYC = 32'(`QRS_CYC_CEIL(`QRS_BURST_BLANK_NS)),
  parameter int unsigned SKIP_PERIOD_CYC = 32'(`QRS_CYC_FLOOR(`QRS_SKIP_PERIOD_NS))
) (
  // Clock and reset.
  input  wire logic              sys_clk_i,
  input  wire logic              srst_i,
  // Sense-input comparators.
  input  wire logic              valley_sense_below_i,
  input  wire logic              output_overvoltage_i,
  input  wire logic              suppression_select_above_i,
  // Current-sense comparators.
  input  wire logic              pwm_reset_i,
  input  wire logic              overcurrent_i,
  input  wire logic              shorted_winding_i,
  // Feedback-level comparators.
  input  wire logic              feedback_above_zl_i,
  input  wire logic              feedback_above_zh_i,
  input  wire logic              feedback_above_r1_i,
  input  wire logic              burst_entry_below_i,
  // Foldback current excess above the first threshold.
  input  wire logic [LIM_W-1:0]  foldback_excess_i,
  // Gate request and status.
  output logic                   gate_drive_output_o,
  output logic                   latched_off_o,
  output logic                   burst_mode_o,
  output qrs_pkg::qrs_cnt3_t     valley_count_o,
  output qrs_pkg::qrs_cnt3_t     skip_count_o,
  output logic [LIM_W-1:0]       cur_limit_level_o
);
  import qrs_pkg::*;

  // ************************************************************
  // Derived cycle counts
  // ************************************************************
  localparam int unsigned TW            = 32;
  localparam int unsigned LEB_CYC       = 32'(`QRS_CYC_CEIL(`QRS_LEADING_BLANK_NS));
  localparam int unsigned SW_BLANK_CYC  = 32'(`QRS_CYC_CEIL(`QRS_SW_BLANK_NS));
  localparam int unsigned OVP_BLANK_CYC = 32'(`QRS_CYC_CEIL(`QRS_OVP_BLANK_NS));
  localparam int unsigned SUPP_LONG_CYC = 32'(`QRS_CYC_CEIL(`QRS_SUPP_LONG_NS));
  localparam int unsigned SUPP_SHRT_CYC = 32'(`QRS_CYC_CEIL(`QRS_SUPP_SHORT_NS));

  // Persistence needed per comparator; only the two fault paths are filtered here.
  function automatic int unsigned blank_of(input int unsigned idx);
    if (idx == `QRS_CMP_SW) begin
      return SW_BLANK_CYC;
    end else if (idx == `QRS_CMP_OVP) begin
      return OVP_BLANK_CYC;
    end else begin
      return 0;
    end
  endfunction

  // ************************************************************
  // Comparator synchronisers
  // ************************************************************
  logic [`QRS_NCMP-1:0] cmp_raw;
  logic [`QRS_NCMP-1:0] cmp_en;
  logic [`QRS_NCMP-1:0] cmp_lvl;
  logic [`QRS_NCMP-1:0] cmp_hit;
  qrs_state_e           st_q;
  qrs_state_e           st_d;

  assign cmp_raw = {burst_entry_below_i, feedback_above_r1_i, feedback_above_zh_i,
                    feedback_above_zl_i, shorted_winding_i, overcurrent_i, pwm_reset_i,
                    suppression_select_above_i, output_overvoltage_i, valley_sense_below_i};

  // Overvoltage only counts during off-time, shorted winding only during on-time.
  always_comb begin
    cmp_en                   = '1;
    cmp_en[`QRS_CMP_OVP]     = (st_q != QRS_ST_ON) && (st_q != QRS_ST_LATCH); // [R4]
    cmp_en[`QRS_CMP_SW]      = (st_q == QRS_ST_ON); // [R13]
  end

  // Every comparator is taken through two flops before any decision reads it.
  for (genvar g = 0; g < `QRS_NCMP; g++) begin : g_cmp
    qrs_cmp_filter #(
      .BLANK_CYC (blank_of(g)),
      .CW        (TW)
    ) u_filt (
      .sys_clk_i (sys_clk_i),
      .srst_i    (srst_i),
      .raw_i     (cmp_raw[g]),
      .en_i      (cmp_en[g]),
      .level_o   (cmp_lvl[g]),
      .hit_o     (cmp_hit[g])
    ); // [R17]
  end

  // ************************************************************
  // Switching state machine and its timers
  // ************************************************************
  logic [TW-1:0] on_cnt_q;
  logic [TW-1:0] on_cnt_d;
  logic [TW-1:0] off_cnt_q;
  logic [TW-1:0] off_cnt_d;
  logic          valley_prev_q;
  logic          valley_prev_d;
  qrs_cnt3_t     valley_q;
  qrs_cnt3_t     valley_d;
  qrs_cnt3_t     skip_q;
  logic          past_leb;
  logic          supp_done;
  logic          max_off;
  logic          turn_on;
  logic          fault;

  // The suppression length follows the sense level live, so a late rise shortens it.
  assign supp_done = cmp_lvl[`QRS_CMP_SUPP_SEL] ?
                     (off_cnt_q >= TW'(SUPP_SHRT_CYC)) :
                     (off_cnt_q >= TW'(SUPP_LONG_CYC)); // [R5]
  assign max_off   = (off_cnt_q >= TW'(MAX_OFF_CYC) - 1'b1); // [R8]
  assign past_leb  = (on_cnt_q >= TW'(LEB_CYC)); // [R10]
  assign fault     = cmp_hit[`QRS_CMP_OVP] || cmp_hit[`QRS_CMP_SW]; // [R4] [R13]
  assign turn_on   = (st_d == QRS_ST_ON) && (st_q != QRS_ST_ON);

  // Next state; a latched fault holds the switch off until reset.
  always_comb begin
    st_d = st_q;
    case (st_q)
      QRS_ST_ON: begin
        if (fault) begin
          st_d = QRS_ST_LATCH;
        end else if (past_leb && (cmp_lvl[`QRS_CMP_PWM] || cmp_lvl[`QRS_CMP_OCL])) begin
          st_d = QRS_ST_SUPP; // [R9] [R12]
        end else if (on_cnt_q >= TW'(MAX_ON_CYC) - 1'b1) begin
          st_d = QRS_ST_SUPP; // [R11]
        end
      end
      QRS_ST_SUPP: begin
        if (fault) begin
          st_d = QRS_ST_LATCH;
        end else if (max_off) begin
          st_d = QRS_ST_ON; // [R8]
        end else if (supp_done) begin
          st_d = QRS_ST_WAIT; // [R6]
        end
      end
      QRS_ST_WAIT: begin
        if (fault) begin
          st_d = QRS_ST_LATCH;
        end else if (max_off || (valley_q >= skip_q)) begin
          st_d = QRS_ST_ON; // [R7] [R8]
        end
      end
      QRS_ST_LATCH: begin
        st_d = QRS_ST_LATCH;
      end
      default: begin
        st_d = QRS_ST_LATCH;
      end
    endcase
  end

  // Timers and valley counter.
  always_comb begin
    on_cnt_d      = '0;
    off_cnt_d     = '0;
    valley_prev_d = cmp_lvl[`QRS_CMP_VALLEY];
    valley_d      = valley_q;
    if (st_q == QRS_ST_ON) begin
      on_cnt_d = on_cnt_q + 1'b1;
    end else if ((st_q != QRS_ST_LATCH) && (off_cnt_q != '1)) begin
      off_cnt_d = off_cnt_q + 1'b1;
    end
    if (turn_on) begin
      valley_d = `QRS_VALLEY_MIN; // [R3]
    end else if ((st_q != QRS_ST_ON) && cmp_lvl[`QRS_CMP_VALLEY] && !valley_prev_q &&
                 (valley_q != `QRS_VALLEY_MAX)) begin
      valley_d = valley_q + 3'h1; // [R1] [R2]
    end
  end

  // Start off and waiting, so the maximum off-time fires the first pulse.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_q          <= QRS_ST_WAIT;
      on_cnt_q      <= '0;
      off_cnt_q     <= '0;
      valley_prev_q <= 1'b0;
      valley_q      <= `QRS_VALLEY_MIN;
    end else begin
      st_q          <= st_d;
      on_cnt_q      <= on_cnt_d;
      off_cnt_q     <= off_cnt_d;
      valley_prev_q <= valley_prev_d;
      valley_q      <= valley_d;
    end
  end

  // ************************************************************
  // Skip counter over the feedback period
  // ************************************************************
  logic [TW-1:0] per_cnt_q;
  logic [TW-1:0] per_cnt_d;
  logic          seen_zl_q;
  logic          seen_zl_d;
  logic          seen_zh_q;
  logic          seen_zh_d;
  logic          seen_r1_q;
  logic          seen_r1_d;
  qrs_cnt3_t     skip_d;
  logic          per_end;

  assign per_end = (per_cnt_q >= TW'(SKIP_PERIOD_CYC) - 1'b1);

  // Flags remember the highest band reached within the period, judged at its end.
  always_comb begin
    per_cnt_d = per_end ? '0 : per_cnt_q + 1'b1;
    seen_zl_d = seen_zl_q || cmp_lvl[`QRS_CMP_FB_ZL];
    seen_zh_d = seen_zh_q || cmp_lvl[`QRS_CMP_FB_ZH];
    seen_r1_d = seen_r1_q || cmp_lvl[`QRS_CMP_FB_R1];
    skip_d    = skip_q;
    if (per_end) begin
      seen_zl_d = 1'b0;
      seen_zh_d = 1'b0;
      seen_r1_d = 1'b0;
      if (seen_r1_q || cmp_lvl[`QRS_CMP_FB_R1]) begin
        skip_d = `QRS_SKIP_MIN; // [R16]
      end else if (seen_zh_q || cmp_lvl[`QRS_CMP_FB_ZH]) begin
        skip_d = (skip_q > `QRS_SKIP_MIN) ? skip_q - 3'h1 : `QRS_SKIP_MIN; // [R16]
      end else if (!(seen_zl_q || cmp_lvl[`QRS_CMP_FB_ZL])) begin
        skip_d = (skip_q < `QRS_SKIP_MAX) ? skip_q + 3'h1 : `QRS_SKIP_MAX; // [R16]
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      per_cnt_q <= '0;
      seen_zl_q <= 1'b0;
      seen_zh_q <= 1'b0;
      seen_r1_q <= 1'b0;
      skip_q    <= `QRS_SKIP_RESET;
    end else begin
      per_cnt_q <= per_cnt_d;
      seen_zl_q <= seen_zl_d;
      seen_zh_q <= seen_zh_d;
      seen_r1_q <= seen_r1_d;
      skip_q    <= skip_d;
    end
  end

  // ************************************************************
  // Burst entry and current limit
  // ************************************************************
  logic [TW-1:0]    burst_cnt_q;
  logic [TW-1:0]    burst_cnt_d;
  logic             burst_q;
  logic             burst_d;
  logic [LIM_W-1:0] limit_q;
  logic [LIM_W-1:0] limit_d;
  logic             burst_cond;

  assign burst_cond = cmp_lvl[`QRS_CMP_FB_EB] && (skip_q == `QRS_SKIP_MAX);

  // The flag is sticky until reset; leaving burst is handled outside this block.
  always_comb begin
    burst_cnt_d = '0;
    burst_d     = burst_q;
    if (burst_cond) begin
      burst_cnt_d = (burst_cnt_q != '1) ? burst_cnt_q + 1'b1 : burst_cnt_q;
      if (burst_cnt_q >= TW'(BURST_BLANK_CYC) - 1'b1) begin
        burst_d = 1'b1; // [R15]
      end
    end
    // Saturating subtraction keeps the limit from wrapping on a large excess.
    limit_d = (foldback_excess_i > LIM_W'(`QRS_CUR_LIMIT_BASE)) ? '0 :
              LIM_W'(`QRS_CUR_LIMIT_BASE) - foldback_excess_i; // [R14]
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      burst_cnt_q <= '0;
      burst_q     <= 1'b0;
      limit_q     <= LIM_W'(`QRS_CUR_LIMIT_BASE);
    end else begin
      burst_cnt_q <= burst_cnt_d;
      burst_q     <= burst_d;
      limit_q     <= limit_d;
    end
  end

  // ************************************************************
  // Outputs, all from flops
  // ************************************************************
  assign gate_drive_output_o = (st_q == QRS_ST_ON);
  assign latched_off_o       = (st_q == QRS_ST_LATCH);
  assign burst_mode_o        = burst_q;
  assign valley_count_o      = valley_q;
  assign skip_count_o        = skip_q;
  assign cur_limit_level_o   = limit_q;

endmodule

/* qrs_checker.sv */
// Concurrent checks on the ports of the quasi-resonant switch timing block.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module qrs_checker #(
  parameter int unsigned LIM_W       = 8,
  parameter int unsigned MAX_OFF_CYC = 12500,
  parameter int unsigned MAX_ON_CYC  = 7500
) (
  // Clock and reset.
  input wire logic               sys_clk_i,
  input wire logic               srst_i,
  // Watched ports.
  input wire logic [LIM_W-1:0]   foldback_excess_i,
  input wire logic               gate_drive_output_o,
  input wire logic               latched_off_o,
  input wire logic               burst_mode_o,
  input wire qrs_pkg::qrs_cnt3_t valley_count_o,
  input wire qrs_pkg::qrs_cnt3_t skip_count_o,
  input wire logic [LIM_W-1:0]   cur_limit_level_o
);
  import qrs_pkg::*;
  localparam int unsigned SUPP_SHORT_CYC = 250;
  localparam int unsigned LEB_CYC        = 55;
  logic [15:0] off_q;
  logic [15:0] off_d;
  logic [15:0] on_q;
  logic [15:0] on_d;

  // Run lengths of each gate level; the opposite level clears them so every pulse is measured alone.
  always_comb begin
    off_d = gate_drive_output_o ? 16'h0000 : off_q + 16'h0001;
    on_d  = gate_drive_output_o ? on_q + 16'h0001 : 16'h0000;
  end

  // Registers of the run lengths.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      off_q <= 16'h0000;
      on_q  <= 16'h0000;
    end else begin
      off_q <= off_d;
      on_q  <= on_d;
    end
  end

  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  sequence s_turn_on;
    !gate_drive_output_o ##1 gate_drive_output_o;
  endsequence
  sequence s_turn_off;
    gate_drive_output_o ##1 !gate_drive_output_o;
  endsequence

  a_valley_no_wrap: assert property (valley_count_o == 3'h7 |=>
    valley_count_o == 3'h7 || $rose(gate_drive_output_o)) else $error("Valley count left its ceiling.");
  a_valley_step: assert property (!gate_drive_output_o |=>
    gate_drive_output_o || valley_count_o - $past(valley_count_o) <= 3'h1) else $error("Valley count jumped.");
  a_valley_clear: assert property (s_turn_on |-> valley_count_o == 3'h0)
    else $error("Valley count not cleared at turn-on.");
  a_latch_hold: assert property (latched_off_o |-> !gate_drive_output_o ##1 latched_off_o)
    else $error("Latched-off state released or gate driven.");
  a_supp_hold: assert property (s_turn_on |-> off_q >= SUPP_SHORT_CYC)
    else $error("Gate rose inside ringing suppression.");
  a_max_off: assert property ((!gate_drive_output_o && !latched_off_o) |-> off_q <= MAX_OFF_CYC)
    else $error("Gate stayed off past the maximum off-time.");
  a_min_on: assert property (s_turn_off |-> latched_off_o || on_q >= LEB_CYC)
    else $error("Gate fell inside leading blank time.");
  a_max_on: assert property (gate_drive_output_o |-> on_q < MAX_ON_CYC)
    else $error("Gate stayed on past the maximum on-time.");
  a_limit_offset: assert property (1'b1 |=>
    cur_limit_level_o == {LIM_W{1'b1}} - $past(foldback_excess_i)) else $error("Current limit offset wrong.");
  a_burst_entry: assert property ($rose(burst_mode_o) |-> $past(skip_count_o) == 3'h7)
    else $error("Burst flag set with skip count below seven.");
  a_burst_sticky: assert property (burst_mode_o |=> burst_mode_o)
    else $error("Burst flag dropped.");
  a_skip_range: assert property (skip_count_o != 3'h0 && (skip_count_o == 3'h1 ||
    skip_count_o - $past(skip_count_o) + 3'h1 <= 3'h2)) else $error("Skip count out of range or jumped.");
endmodule

bind qrs_switch_timing qrs_checker #(
  .LIM_W       (LIM_W),
  .MAX_OFF_CYC (MAX_OFF_CYC),
  .MAX_ON_CYC  (MAX_ON_CYC)
) u_qrs_checker (
  .sys_clk_i           (sys_clk_i),
  .srst_i              (srst_i),
  .foldback_excess_i   (foldback_excess_i),
  .gate_drive_output_o (gate_drive_output_o),
  .latched_off_o       (latched_off_o),
  .burst_mode_o        (burst_mode_o),
  .valley_count_o      (valley_count_o),
  .skip_count_o        (skip_count_o),
  .cur_limit_level_o   (cur_limit_level_o)
);

/* qrs_partner.sv */
// Behavioural model of the sense comparators and the switch seen by the timing block.
// Assumes the bench sets the number of ring valleys and the current ramp length.
`timescale 1ns/1ps
module qrs_partner (
  // Clock and gate request.
  input  wire logic       sys_clk_i,
  input  wire logic       gate_i,
  // Controls from the bench.
  input  wire logic [7:0] on_cyc_i,
  input  wire logic [3:0] n_valley_i,
  // Comparator levels.
  output logic            valley_below_o,
  output logic            pwm_reset_o
);
  logic       gate_q = 1'b0;
  logic [9:0] t_q    = 10'h000;

  // Time since the last gate change; the ring has a 32-cycle period and dips low for half of it.
  // A damped ring stops after the set number of valleys, which is how the maximum off-time is reached.
  always @(posedge sys_clk_i) begin
    gate_q         <= gate_i;
    t_q            <= (gate_i != gate_q) ? 10'h000 : t_q + 10'h001;
    pwm_reset_o    <= gate_i && gate_q && (t_q >= {2'h0, on_cyc_i});
    valley_below_o <= !gate_i && t_q[4] && (t_q[9:5] < {1'b0, n_valley_i});
  end
endmodule

/* test_qrs_switch_timing.sv */
// Self-checking bench of the quasi-resonant switch timing block with shortened long counts.
// Assumes the checker is bound to the block and the partner models the sense comparators.
`timescale 1ns/1ps
module test_qrs_switch_timing;
  import qrs_pkg::*;
  localparam int unsigned OFFC = 800;
  localparam int unsigned ONC  = 100;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic valley;
  logic pwm;
  logic ovp = 1'b0;
  logic supp_hi = 1'b0;
  logic oc = 1'b0;
  logic sw = 1'b0;
  logic zl = 1'b0;
  logic zh = 1'b0;
  logic r1 = 1'b1;
  logic beb = 1'b0;
  logic [7:0] excess = 8'h00;
  logic [7:0] on_cyc = 8'h46;
  logic [3:0] n_val = 4'h0;
  logic gate;
  logic latched;
  logic burst;
  qrs_cnt3_t vcnt;
  qrs_cnt3_t scnt;
  logic [7:0] lim;
  int n_fail = 0;
  int n_compared = 0;

  qrs_switch_timing #(.LIM_W(8), .MAX_OFF_CYC(OFFC), .MAX_ON_CYC(ONC), .BURST_BLANK_CYC(50),
    .SKIP_PERIOD_CYC(100)) uut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .valley_sense_below_i(valley),
    .output_overvoltage_i(ovp), .suppression_select_above_i(supp_hi), .pwm_reset_i(pwm), .overcurrent_i(oc),
    .shorted_winding_i(sw), .feedback_above_zl_i(zl), .feedback_above_zh_i(zh), .feedback_above_r1_i(r1),
    .burst_entry_below_i(beb), .foldback_excess_i(excess), .gate_drive_output_o(gate), .latched_off_o(latched),
    .burst_mode_o(burst), .valley_count_o(vcnt), .skip_count_o(scnt), .cur_limit_level_o(lim));
  qrs_partner u_partner (.sys_clk_i(sys_clk_i), .gate_i(gate), .on_cyc_i(on_cyc), .n_valley_i(n_val),
    .valley_below_o(valley), .pwm_reset_o(pwm));

  // Free-running 250 MHz clock.
  initial begin
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic finish_test();
    if (n_fail == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Waits past the next clock edges and lets their updates settle.
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  // Counts cycles until the gate shows the wanted level; a hang ends the run.
  task automatic wait_gate(input logic lvl, output int n);
    n = 0;
    while (gate !== lvl && n < 2000) begin
      cyc(1);
      n++;
    end
    if (gate !== lvl) begin
      n_fail++;
      finish_test();
    end
  endtask
  task automatic do_reset();
    @(posedge sys_clk_i);
    srst_i <= 1'b1;
    repeat (16) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    cyc(1);
    check({gate, latched, burst, vcnt, scnt, lim}, {3'h0, 3'h0, 3'h1, 8'hFF});
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_limit();
    @(posedge sys_clk_i);
    excess <= 8'h30;
    cyc(3);
    check(lim, 8'hCF);
    @(posedge sys_clk_i);
    excess <= 8'hFF;
    cyc(3);
    check(lim, 8'h00);
    @(posedge sys_clk_i);
    excess <= 8'h00;
  endtask
  task automatic t_max_off();
    int n;
    wait_gate(1'b1, n);
    wait_gate(1'b0, n);
    check(32'(n >= 72 && n <= 78), 32'h1);
    wait_gate(1'b1, n);
    check(n, OFFC);
    check(vcnt, 3'h0);
  endtask
  task automatic t_supp(input logic sel, input int lo);
    int n;
    @(posedge sys_clk_i);
    supp_hi <= sel;
    n_val <= 4'hA;
    cyc(1);
    wait_gate(1'b1, n);
    wait_gate(1'b0, n);
    cyc(240);
    check(vcnt, 3'h7);
    wait_gate(1'b1, n);
    check(32'(n + 240 >= lo && n + 240 <= lo + 7), 32'h1);
    check(vcnt, 3'h0);
  endtask
  task automatic t_on_limits();
    int n;
    on_cyc <= 8'h00;
    wait_gate(1'b0, n);
    wait_gate(1'b1, n);
    wait_gate(1'b0, n);
    check(32'(n >= 55 && n <= 60), 32'h1);
    on_cyc <= 8'hFF;
    wait_gate(1'b1, n);
    cyc(70);
    @(posedge sys_clk_i);
    oc <= 1'b1;
    cyc(1);
    wait_gate(1'b0, n);
    check(32'(n >= 1 && n <= 5), 32'h1);
    @(posedge sys_clk_i);
    oc <= 1'b0;
    wait_gate(1'b1, n);
    wait_gate(1'b0, n);
    check(n, ONC);
  endtask
  task automatic t_skip();
    int n;
    @(posedge sys_clk_i);
    r1 <= 1'b0;
    beb <= 1'b1;
    for (n = 0; n < 1000 && scnt !== 3'h7; n++) cyc(1);
    check(32'(n >= 500 && n <= 800), 32'h1);
    check(burst, 1'b0);
    cyc(60);
    check(burst, 1'b1);
    @(posedge sys_clk_i);
    zl <= 1'b1;
    cyc(250);
    check(scnt, 3'h7);
    @(posedge sys_clk_i);
    zh <= 1'b1;
    cyc(250);
    check(32'(scnt == 3'h4 || scnt == 3'h5), 32'h1);
    @(posedge sys_clk_i);
    r1 <= 1'b1;
    cyc(250);
    check({scnt, burst}, {3'h1, 1'b1});
    @(posedge sys_clk_i);
    {zl, zh, beb} <= 3'h0;
  endtask
  task automatic t_ovp();
    int n;
    n_val <= 4'h0;
    on_cyc <= 8'h46;
    wait_gate(1'b1, n);
    wait_gate(1'b0, n);
    @(posedge sys_clk_i);
    ovp <= 1'b1;
    repeat (100) @(posedge sys_clk_i);
    ovp <= 1'b0;
    cyc(5);
    check(latched, 1'b0);
    @(posedge sys_clk_i);
    ovp <= 1'b1;
    for (n = 0; n < 400 && latched !== 1'b1; n++) cyc(1);
    check(32'(n >= 249 && n <= 256), 32'h1);
    @(posedge sys_clk_i);
    ovp <= 1'b0;
  endtask
  task automatic t_short();
    int n;
    on_cyc <= 8'hFF;
    wait_gate(1'b1, n);
    @(posedge sys_clk_i);
    sw <= 1'b1;
    repeat (20) @(posedge sys_clk_i);
    sw <= 1'b0;
    cyc(1);
    wait_gate(1'b0, n);
    check(latched, 1'b0);
    wait_gate(1'b1, n);
    @(posedge sys_clk_i);
    sw <= 1'b1;
    for (n = 0; n < 100 && latched !== 1'b1; n++) cyc(1);
    check(32'(n >= 47 && n <= 53), 32'h1);
    @(posedge sys_clk_i);
    sw <= 1'b0;
  endtask

  // Main sequence.
  initial begin
    do_reset();
    t_limit();
    t_max_off();
    t_supp(1'b0, 625);
    t_supp(1'b1, 250);
    t_on_limits();
    t_skip();
    t_ovp();
    do_reset();
    t_short();
    do_reset();
    finish_test();
  end
endmodule
